//--- rtl/acs_pkg.sv
// Purpose: shared constants and types for the conversion sequencer
// Assumes: 32-bit classic Wishbone, byte addresses, one register per word
// Notes:   fields of every register sit in the low byte
package acs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_SCR = 8'h00;
  localparam logic [7:0] OFS_CLK = 8'h04;
  localparam logic [7:0] OFS_RH  = 8'h08;
  localparam logic [7:0] OFS_RL  = 8'h0C;

  // conv_status_control_reg fields
  localparam int unsigned SCR_CH_LSB   = 0;
  localparam int unsigned SCR_CH_MSB   = 4;
  localparam int unsigned SCR_CONT_BIT = 5;
  localparam int unsigned SCR_CONV_INTERRUPT_ENABLE_BIT = 6;
  localparam logic [4:0]  CH_OFF       = 5'h1F;

  // conv_clock_config_reg fields
  localparam int unsigned CLK_DIV_LSB   = 0;
  localparam int unsigned CLK_DIV_MSB   = 1;
  localparam int unsigned CLK_RES10_BIT = 2;
  localparam int unsigned CLK_HWTRG_BIT = 3;
  localparam int unsigned CLK_ACLK_BIT  = 4;

  // Timing, conversion and interrupt constants
  localparam logic [2:0]  SAMPLE_LAST = 3'h3;
  localparam logic [2:0]  SETTLE_LAST = 3'h2;
  localparam logic [3:0]  TOP_BIT10   = 4'h9;
  localparam logic [3:0]  TOP_BIT8    = 4'h7;
  localparam logic [15:0] VEC_ADDR    = 16'hFFDE;
  localparam logic [4:0]  IRQ_SLOT    = 5'h0F;

  typedef enum logic [1:0] {ACS_IDLE, ACS_SAMPLE, ACS_TRIAL} acs_sar_state_t;
  typedef enum logic [2:0] {ACS_R_SCR, ACS_R_CLK, ACS_R_RH, ACS_R_RL, ACS_R_NONE} acs_reg_t;

  typedef struct packed {
    acs_sar_state_t state;
    logic [2:0]     cnt;
    logic [3:0]     bit_ix;
    logic [9:0]     code;
    logic [9:0]     result;
    logic           res10;
    logic           done;
    logic           busy;
    logic           sample;
  } acs_sar_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } acs_div_t;

  function automatic acs_reg_t acs_decode(input logic [7:0] adr);
    unique case (adr)
      OFS_SCR: acs_decode = ACS_R_SCR;
      OFS_CLK: acs_decode = ACS_R_CLK;
      OFS_RH:  acs_decode = ACS_R_RH;
      OFS_RL:  acs_decode = ACS_R_RL;
      default: acs_decode = ACS_R_NONE;
    endcase
  endfunction : acs_decode

  function automatic logic [2:0] acs_div_limit(input logic [1:0] sel);
    acs_div_limit = 3'((4'h1 << sel) - 4'h1);
  endfunction : acs_div_limit

endpackage : acs_pkg

//--- rtl/acs_clk_div.sv
// Purpose: converter clock divider, one tick per divided period
// Assumes: clr restarts the period
// Notes:   divide by 1, 2, 4 or 8
`timescale 1ns/1ps
module acs_clk_div (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       clr,
  input  wire logic [1:0] div_sel,
  output logic            tick
);
  import acs_pkg::*;

  acs_div_t st_q;
  acs_div_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = !clr && (st_q.cnt == acs_div_limit(div_sel));
    st_d.cnt  = (clr || st_d.tick) ? 3'h0 : 3'(st_q.cnt + 3'h1);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

  property p_div8;
    @(posedge ref_clk) disable iff (!nrst || clr)
    (tick && div_sel == 2'h3) |=> (!tick) [*7] ##1 tick;
  endproperty
  a_div8: assert property (p_div8) else $error("divide-by-8 period wrong");

endmodule : acs_clk_div

//--- rtl/acs_sar.sv
// Purpose: successive approximation bit sequencer
// Assumes: cmp is synchronised, high when input is above the trial level
// Notes:   start wins over abort; 8-bit result is right justified
`timescale 1ns/1ps
module acs_sar (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       res10,
  input  wire logic       cmp,
  output logic            busy,
  output logic            done,
  output logic            sample,
  output logic [9:0]      result,
  output logic [9:0]      dac_code
);
  import acs_pkg::*;

  acs_sar_t   st_q;
  acs_sar_t   st_d;
  logic [3:0] nxt;

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    nxt = 4'(st_q.bit_ix - 4'h1);
    if (start) begin
      st_d.state = ACS_SAMPLE;
      st_d.cnt   = 3'h0;
      st_d.code  = '0;
      st_d.res10 = res10;
    end else if (abort) begin
      st_d.state = ACS_IDLE;
      st_d.code  = '0;
    end else begin
      unique case (st_q.state)
        ACS_IDLE: begin
        end
        ACS_SAMPLE: if (tick) begin
          if (st_q.cnt == SAMPLE_LAST) begin
            st_d.state  = ACS_TRIAL;
            st_d.cnt    = 3'h0;
            st_d.bit_ix = st_q.res10 ? TOP_BIT10 : TOP_BIT8;
            st_d.code[st_d.bit_ix] = 1'b1;
          end else begin
            st_d.cnt = 3'(st_q.cnt + 3'h1);
          end
        end
        ACS_TRIAL: begin
          // Comparator sync lags each code change by two cycles
          if (st_q.cnt != SETTLE_LAST) begin
            st_d.cnt = 3'(st_q.cnt + 3'h1);
          end
          if (tick && st_q.cnt == SETTLE_LAST) begin
            st_d.code[st_q.bit_ix] = cmp;
            if (st_q.bit_ix == 4'h0) begin
              st_d.state  = ACS_IDLE;
              st_d.done   = 1'b1;
              st_d.result = st_d.code;
            end else begin
              st_d.bit_ix    = nxt;
              st_d.code[nxt] = 1'b1;
              st_d.cnt       = 3'h0;
            end
          end
        end
      endcase
    end
    st_d.busy   = st_d.state != ACS_IDLE;
    st_d.sample = st_d.state == ACS_SAMPLE;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy     = st_q.busy;
  assign done     = st_q.done;
  assign sample   = st_q.sample;
  assign result   = st_q.result;
  assign dac_code = st_q.code;

  property p_res8;
    @(posedge ref_clk) disable iff (!nrst)
    (done && !st_q.res10) |-> result[9:8] == 2'h0;
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit result has upper bits set");

endmodule : acs_sar

//--- rtl/acs_top.sv
// Purpose: conversion sequencer with Wishbone register slave
// Assumes: stop_mode and the bus are on ref_clk; trigger and comparator are async
// Notes:   registers at 0x00, 0x04, 0x08, 0x0C; others read zero
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps

module acs_top (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_wr,
  output logic      [31:0] wb_dat_rd,
  output logic             wb_ack,
  input  wire logic        hw_trigger,
  input  wire logic        cmp_in,
  input  wire logic        stop_mode,
  output logic      [4:0]  chan_sel,
  output logic             sample,
  output logic      [9:0]  dac_code,
  output logic             conv_busy,
  output logic             conv_irq,
  output logic      [15:0] irq_vector,
  output logic      [4:0]  irq_slot
);
  import acs_pkg::*;

  typedef struct packed {
    logic        trig_s1;
    logic        trig_s2;
    logic        trig_prev;
    logic        cmp_s1;
    logic        cmp_s2;
    logic        stop_prev;
    logic        ack;
    logic [31:0] rdat;
    logic [4:0]  ch;
    logic        cont;
    logic        conv_interrupt_enable;
    logic        conversion_complete_flag;
    logic [1:0]  div;
    logic        res10;
    logic        hwtrig;
    logic        aclk;
    logic [1:0]  rh;
    logic [7:0]  rl;
    logic        hi_pend;
    logic        irq;
    logic        start;
    logic        abort;
    logic [15:0] vec;
    logic [4:0]  slot;
  } acs_top_t;

  acs_top_t   st_q;
  acs_top_t   st_d;
  acs_reg_t   rsel;
  logic       wr;
  logic       rd;
  logic       wr_scr;
  logic       wr_clk;
  logic       trig_edge;
  logic       stop_entry;
  logic       accept;
  logic       blocked;
  logic       div_tick;
  logic       sar_busy;
  logic       sar_done;
  logic       sar_sample;
  logic [9:0] sar_result;
  logic [9:0] sar_code;

  acs_clk_div u_div (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .clr     (st_q.start || st_q.abort),
    .div_sel (st_q.div),
    .tick    (div_tick)
  );

  acs_sar u_sar (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .tick     (div_tick),
    .start    (st_q.start),
    .abort    (st_q.abort),
    .res10    (st_q.res10),
    .cmp      (st_q.cmp_s2),
    .busy     (sar_busy),
    .done     (sar_done),
    .sample   (sar_sample),
    .result   (sar_result),
    .dac_code (sar_code)
  );

  always_comb begin
    st_d = st_q;
    st_d.trig_s1   = hw_trigger;
    st_d.trig_s2   = st_q.trig_s1;
    st_d.trig_prev = st_q.trig_s2;
    st_d.cmp_s1    = cmp_in;
    st_d.cmp_s2    = st_q.cmp_s1;
    st_d.stop_prev = stop_mode;
    st_d.ack       = wb_cyc && wb_stb && !st_q.ack;
    st_d.start     = 1'b0;
    st_d.abort     = 1'b0;
    st_d.vec       = VEC_ADDR;
    st_d.slot      = IRQ_SLOT;

    rsel       = acs_decode(wb_adr);
    wr         = st_d.ack && wb_we && wb_sel[0];
    rd         = st_d.ack && !wb_we;
    wr_scr     = wr && rsel == ACS_R_SCR;
    wr_clk     = wr && rsel == ACS_R_CLK;
    trig_edge  = st_q.trig_s2 && !st_q.trig_prev;
    stop_entry = stop_mode && !st_q.stop_prev && !st_q.aclk;
    accept     = sar_done && !st_q.start && !st_q.abort;
    blocked    = accept && st_q.res10 && st_q.hi_pend;

    // Read data and read side effects
    st_d.rdat = 32'h0;
    if (rd) begin
      unique case (rsel)
        ACS_R_SCR:  st_d.rdat = {24'h0, st_q.conversion_complete_flag, st_q.conv_interrupt_enable, st_q.cont, st_q.ch};
        ACS_R_CLK:  st_d.rdat = {27'h0, st_q.aclk, st_q.hwtrig, st_q.res10, st_q.div};
        ACS_R_RH:   st_d.rdat = {30'h0, st_q.rh};
        ACS_R_RL:   st_d.rdat = {24'h0, st_q.rl};
        ACS_R_NONE: st_d.rdat = 32'h0;
      endcase
      if (rsel == ACS_R_RH && st_q.res10) begin
        st_d.hi_pend = 1'b1;
      end
      if (rsel == ACS_R_RL) begin
        st_d.hi_pend = 1'b0;
        st_d.conversion_complete_flag    = 1'b0;
      end
    end

    // Hardware trigger
    if (trig_edge && st_q.hwtrig && !sar_busy && st_q.ch != CH_OFF && !stop_mode) begin
      st_d.start = 1'b1;
    end

    // Finished conversion
    if (accept) begin
      if (blocked) begin
        st_d.start = 1'b1;
      end else begin
        st_d.rh    = st_q.res10 ? sar_result[9:8] : 2'h0;
        st_d.rl    = sar_result[7:0];
        st_d.conversion_complete_flag  = 1'b1;
        st_d.start = st_d.start || st_q.cont;
      end
    end

    // Clock configuration write
    if (wr_clk) begin
      st_d.div    = wb_dat_wr[CLK_DIV_MSB:CLK_DIV_LSB];
      st_d.res10  = wb_dat_wr[CLK_RES10_BIT];
      st_d.hwtrig = wb_dat_wr[CLK_HWTRG_BIT];
      st_d.aclk   = wb_dat_wr[CLK_ACLK_BIT];
      st_d.abort  = 1'b1;
      st_d.start  = 1'b0;
    end

    if (stop_entry) begin
      st_d.abort = 1'b1;
      st_d.start = 1'b0;
    end

    // Status and control write
    if (wr_scr) begin
      st_d.ch    = wb_dat_wr[SCR_CH_MSB:SCR_CH_LSB];
      st_d.cont  = wb_dat_wr[SCR_CONT_BIT];
      st_d.conv_interrupt_enable  = wb_dat_wr[SCR_CONV_INTERRUPT_ENABLE_BIT];
      st_d.conversion_complete_flag  = accept && !blocked;
      st_d.abort = 1'b1;
      st_d.start = (st_d.ch != CH_OFF) && !st_q.hwtrig;
    end

    st_d.irq = st_d.conversion_complete_flag && st_d.conv_interrupt_enable;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q    <= '0;
      st_q.ch <= CH_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_rd  = st_q.rdat;
  assign wb_ack     = st_q.ack;
  assign chan_sel   = st_q.ch;
  assign sample     = sar_sample;
  assign dac_code   = sar_code;
  assign conv_busy  = sar_busy;
  assign conv_irq   = st_q.irq;
  assign irq_vector = st_q.vec;
  assign irq_slot   = st_q.slot;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_restart;
    st_q.start ##1 conv_busy;
  endsequence

  sequence s_stopped;
    (st_q.abort && !st_q.start) ##1 !conv_busy;
  endsequence

  property p_sw_start;
    (wr_scr && wb_dat_wr[4:0] != CH_OFF && !st_q.hwtrig) |=> s_restart;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("write did not restart");

  property p_off;
    (wr_scr && wb_dat_wr[4:0] == CH_OFF) |=> s_stopped;
  endproperty
  a_off: assert property (p_off) else $error("channel off still converts");

  property p_clk_abort;
    wr_clk |=> s_stopped;
  endproperty
  a_clk_abort: assert property (p_clk_abort) else $error("config write did not abort");

  property p_stop;
    (stop_entry && !wr_scr) |=> s_stopped;
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry did not abort");

  property p_keep;
    ((wr_clk || stop_entry) && !accept) |=> $stable(st_q.rl) && $stable(st_q.rh);
  endproperty
  a_keep: assert property (p_keep) else $error("abort altered results");

  property p_done;
    (accept && !blocked) |=> st_q.conversion_complete_flag && st_q.rl == $past(sar_result[7:0]);
  endproperty
  a_done: assert property (p_done) else $error("result not transferred");

  property p_block;
    (blocked && !wr_clk && !stop_entry && !wr_scr) |=> s_restart and (!$rose(st_q.conversion_complete_flag) && $stable(st_q.rl));
  endproperty
  a_block: assert property (p_block) else $error("blocked transfer mishandled");

  property p_irq;
    ($rose(st_q.conversion_complete_flag) && st_q.conv_interrupt_enable) |-> conv_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_cont;
    (accept && !blocked && st_q.cont && !wr_clk && !stop_entry && !wr_scr) |=> s_restart;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous restart missing");

  property p_hw;
    (trig_edge && st_q.hwtrig && !sar_busy && st_q.ch != CH_OFF && !stop_mode && !wr_clk && !wr_scr)
      |=> s_restart;
  endproperty
  a_hw: assert property (p_hw) else $error("trigger did not start");

endmodule : acs_top

//--- bench/acs_analog_model.sv
// Purpose: analog sampling core seen by the sequencer
// Assumes: input held half an LSB above its code, so cmp is level >= trial
// Notes:   comparator toggles while no channel is selected
`timescale 1ns/1ps
module acs_analog_model (
  input  wire logic             ref_clk,
  input  wire logic [4:0]       chan_sel,
  input  wire logic             sample,
  input  wire logic [7:0][9:0]  levels,
  input  wire logic [9:0]       dac_code,
  output logic                  cmp_in
);
  import acs_pkg::*;
  logic [9:0] held_q;
  logic       junk_q;

  // Sample and hold of the one selected channel
  always_ff @(posedge ref_clk) begin
    junk_q <= ~junk_q;
    if (sample) begin
      held_q <= levels[chan_sel[2:0]];
    end
  end

  assign cmp_in = (chan_sel == CH_OFF) ? junk_q : (held_q >= dac_code);

  initial begin
    held_q = 10'h000;
    junk_q = 1'b0;
  end
endmodule : acs_analog_model

//--- bench/test_acs_top.sv
// Purpose: register level tests of the conversion sequencer
// Assumes: one bus access at a time, analog model on the far side
// Notes:   results derived from the channel levels set here
`timescale 1ns/1ps
module test_acs_top;
  import acs_pkg::*;
  logic             ref_clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic             hw_trigger, cmp_in, stop_mode, sample, conv_busy, conv_irq;
  logic [7:0]       wb_adr;
  logic [3:0]       wb_sel;
  logic [31:0]      wb_dat_wr, wb_dat_rd, q;
  logic [4:0]       chan_sel, irq_slot;
  logic [9:0]       dac_code;
  logic [15:0]      irq_vector;
  logic [7:0][9:0]  lv;
  int               n_fail, num_checks, d, n, e;

  acs_top DUT (.ref_clk, .nrst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_wr,
    .wb_dat_rd, .wb_ack, .hw_trigger, .cmp_in, .stop_mode, .chan_sel, .sample, .dac_code,
    .conv_busy, .conv_irq, .irq_vector, .irq_slot);
  acs_analog_model u_ana (.ref_clk, .chan_sel, .sample, .levels(lv), .dac_code, .cmp_in);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat, output logic [31:0] r);
    @(posedge ref_clk);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat_wr <= dat; wb_sel <= 4'hF;
    do @(posedge ref_clk); while (wb_ack !== 1'b1);
    r = wb_dat_rd;
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic [31:0] r;
    wb(1'b1, a, dat, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input string what, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask : rd

  // Poll status until the complete flag shows
  task automatic wait_flag();
    int i;
    for (i = 0; i < 200; i++) begin
      wb(1'b0, OFS_SCR, 32'h0, q);
      if (q[7] === 1'b1) break;
    end
    chk("complete_flag", 32'h1, {31'h0, q[7]});
  endtask : wait_flag

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("BAD watchdog expired");
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 8'h00; wb_sel = 4'h0;
    wb_dat_wr = 32'h0; hw_trigger = 1'b0; stop_mode = 1'b0; n_fail = 0; num_checks = 0;
    lv = '0; lv[1] = 10'h3FF; lv[2] = 10'h2A5; lv[3] = 10'h0C3;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(OFS_SCR, "scr_reset", 32'h1F);
    rd(OFS_RH, "rh_reset", 32'h0);
    rd(OFS_RL, "rl_reset", 32'h0);
    rd(8'h10, "unmapped", 32'h0);
    chk("irq_vector", 32'hFFDE, irq_vector);
    chk("irq_slot", 32'hF, irq_slot);
    $display("test reset done");
    wr(OFS_CLK, 32'h04);
    wr(OFS_SCR, 32'h42);
    chk("chan_sel", 32'h2, chan_sel);
    wait_flag();
    chk("irq_on", 32'h1, conv_irq);
    rd(OFS_RH, "rh10", 32'h2);
    rd(OFS_RL, "rl10", 32'hA5);
    chk("irq_clear", 32'h0, conv_irq);
    wr(OFS_CLK, 32'h00);
    wr(OFS_SCR, 32'h01);
    wait_flag();
    chk("irq_masked", 32'h0, conv_irq);
    rd(OFS_RH, "rh8", 32'h0);
    rd(OFS_RL, "rl8", 32'hFF);
    $display("test single done");
    wr(OFS_CLK, 32'h04);
    wr(OFS_SCR, 32'h02);
    wait_flag();
    rd(OFS_RH, "rh_split", 32'h2);
    lv[2] = 10'h155;
    wr(OFS_SCR, 32'h02);
    repeat (100) @(posedge ref_clk);
    wb(1'b0, OFS_SCR, 32'h0, q);
    chk("flag_blocked", 32'h0, {31'h0, q[7]});
    rd(OFS_RL, "rl_kept", 32'hA5);
    wait_flag();
    rd(OFS_RH, "rh_new", 32'h1);
    rd(OFS_RL, "rl_new", 32'h55);
    $display("test blocking done");
    wr(OFS_SCR, 32'h23);
    wait_flag();
    rd(OFS_RL, "rl_cont", 32'hC3);
    wait_flag();
    wr(OFS_SCR, 32'h1F);
    repeat (10) @(posedge ref_clk);
    chk("busy_off", 32'h0, conv_busy);
    repeat (100) @(posedge ref_clk);
    chk("busy_stays_off", 32'h0, conv_busy);
    $display("test continuous done");
    lv[2] = 10'h100;
    wr(OFS_CLK, 32'h07);
    wr(OFS_SCR, 32'h02);
    repeat (20) @(posedge ref_clk);
    chk("busy_run", 32'h1, conv_busy);
    wr(OFS_CLK, 32'h07);
    repeat (4) @(posedge ref_clk);
    chk("busy_clk_abort", 32'h0, conv_busy);
    repeat (150) @(posedge ref_clk);
    rd(OFS_RL, "rl_after_abort", 32'hC3);
    wr(OFS_SCR, 32'h02);
    repeat (20) @(posedge ref_clk);
    stop_mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("busy_stop_abort", 32'h0, conv_busy);
    stop_mode <= 1'b0;
    repeat (150) @(posedge ref_clk);
    rd(OFS_RL, "rl_after_stop", 32'hC3);
    wr(OFS_SCR, 32'h02);
    repeat (20) @(posedge ref_clk);
    wr(OFS_SCR, 32'h03);
    wait_flag();
    rd(OFS_RL, "rl_restart", 32'hC3);
    $display("test abort done");
    wr(OFS_CLK, 32'h0C);
    wr(OFS_SCR, 32'h02);
    repeat (60) @(posedge ref_clk);
    wb(1'b0, OFS_SCR, 32'h0, q);
    chk("no_sw_start", 32'h0, {31'h0, q[7]});
    hw_trigger <= 1'b1;
    repeat (3) @(posedge ref_clk);
    hw_trigger <= 1'b0;
    wait_flag();
    rd(OFS_RH, "rh_hw", 32'h1);
    $display("test trigger done");
    for (d = 0; d < 4; d++) begin
      wr(OFS_CLK, 32'h04 | d);
      wr(OFS_SCR, 32'h02);
      n = 0;
      for (int i = 0; i < 10 && conv_busy !== 1'b1; i++) @(posedge ref_clk);
      while (conv_busy === 1'b1 && n < 300) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      e = (d == 0) ? 35 : (d == 1) ? 49 : 1 + 14 * (1 << d);
      chk("conv_len", 32'h1, 32'((n >= e - 4) && (n <= e + 4)));
    end
    $display("test divider done");
    tally_and_finish();
  end
endmodule : test_acs_top
